// file: core/port_pin_control.sv
// two general purpose ports with pull, open-drain and modulation override
// Functional notes
// RQ1 - first port pull polarity 1 gives pull-down, 0 gives pull-up.
// RQ2 - with the CAN active a pull-down request on the receive pin is void.
// RQ3 - open-drain outputs drive low for 0 and float for 1.
// RQ4 - open-drain bits 5..0 pick open-drain per output pin, inert on inputs.
// RQ5 - the reserved slot reads zero and ignores writes.
// RQ6 - a second port output pin drives its stored data bit.
// RQ7 - data read gives the stored bit where direction is 1, else the pin.
// RQ8 - modulation overrides pins 5..0 per channel, pin 5 also on shutdown.
// RQ9 - pin interrupts arise on inputs and on outputs alike.
// RQ10 - the input register always reads the buffered pin state.
// RQ11 - writes to the input register are ignored.
// RQ12 - a direction bit of 1 makes an output, 0 an input.
// RQ13 - an enabled channel forces output without touching the direction bit.
// RQ14 - shutdown forces pin 5 to input without touching the direction bit.
// RQ15 - bit 6 of the second port reads zero and ignores writes.
//
// Decided for this implementation: the Avalon-MM slave port.
`timescale 1ns/1ns
module port_pin_control #(
	parameter int FIRST_WIDTH = port_pin_pkg::FIRST_W,
	parameter int SECOND_WIDTH = port_pin_pkg::SECOND_W
) (
	input wire logic SYS_CLK_I,
	input wire logic RESET_N_I,
	input wire logic [port_pin_pkg::ADDR_W-1:0] AVS_ADDRESS_I,
	input wire logic AVS_READ_I,
	input wire logic AVS_WRITE_I,
	input wire logic [31:0] AVS_WRITEDATA_I,
	input wire logic [3:0] AVS_BYTEENABLE_I,
	output logic [31:0] AVS_READDATA_O,
	output logic AVS_WAITREQUEST_O,
	input wire logic [FIRST_WIDTH-1:0] FIRST_PIN_I,
	input wire logic [FIRST_WIDTH-1:0] FIRST_OUT_VALUE_I,
	input wire logic [FIRST_WIDTH-1:0] FIRST_OUT_DIR_I,
	input wire logic [FIRST_WIDTH-1:0] FIRST_PULL_EN_I,
	input wire logic CAN_ACTIVE_I,
	output logic [FIRST_WIDTH-1:0] FIRST_PIN_O,
	output logic [FIRST_WIDTH-1:0] FIRST_PIN_OE_O,
	output logic [FIRST_WIDTH-1:0] FIRST_PULL_UP_O,
	output logic [FIRST_WIDTH-1:0] FIRST_PULL_DOWN_O,
	input wire logic [SECOND_WIDTH-1:0] SECOND_PIN_I,
	input wire logic [5:0] PWM_CHANNEL_EN_I,
	input wire logic [5:0] PWM_VALUE_I,
	input wire logic PWM_SHUTDOWN_EN_I,
	output logic [SECOND_WIDTH-1:0] SECOND_PIN_O,
	output logic [SECOND_WIDTH-1:0] SECOND_PIN_OE_O,
	output logic [SECOND_WIDTH-1:0] SECOND_PIN_SYNC_O,
	output logic IRQ_O
);
	import port_pin_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// registers and synchronisers
	logic [7:0] second_data;
	logic [7:0] second_dir;
	logic [7:0] first_polarity;
	logic [7:0] first_open_drain;
	logic [7:0] irq_status;
	logic [7:0] irq_mask;
	logic [SECOND_WIDTH-1:0] s_meta;
	logic [SECOND_WIDTH-1:0] s_a;
	logic [SECOND_WIDTH-1:0] s_b;
	logic [SECOND_WIDTH-1:0] s_stable;
	logic [SECOND_WIDTH-1:0] s_prev;
	logic primed;
	logic [SETTLE_W-1:0] settle_cnt;
	logic pending;
	logic pend_read;
	typedef enum logic [1:0] {
		BUS_IDLE = 2'b01,
		BUS_ANSWER = 2'b10
	} bus_state_e;
	bus_state_e bus_state;
	bus_state_e next_bus_state;
	bus_req_s req;
	pull_ctl_s pull;

	function automatic logic hit(input logic [ADDR_W-1:0] a,
			input logic [ADDR_W-1:0] ofs);
		hit = (a == ofs);
	endfunction

	// direction picks the stored bit or the filtered pin, bit by bit
	function automatic logic [7:0] readback(input logic [7:0] dir,
			input logic [7:0] data, input logic [7:0] pin);
		readback = (dir & data) | (~dir & pin);
	endfunction

	assign req.read = AVS_READ_I;
	assign req.write = AVS_WRITE_I;
	assign req.address = AVS_ADDRESS_I;
	assign req.writedata = AVS_WRITEDATA_I;

	////////////////////////////////////////////////////////////////////////
	// pin input synchroniser, change accepted when stages two and three agree
	always_ff @(posedge SYS_CLK_I) begin
		if (!RESET_N_I) begin
			s_meta <= '0;
			s_a <= '0;
			s_b <= '0;
		end else begin
			s_meta <= SECOND_PIN_I;
			s_a <= s_meta;
			s_b <= s_a;
		end
	end

	// per-bit filter: a level is taken once two stages agree
	for (genvar g = 0; g < SECOND_WIDTH; g++) begin : g_filter
		always_ff @(posedge SYS_CLK_I) begin
			if (!RESET_N_I) begin
				s_stable[g] <= 1'b0;
			end else if (s_a[g] == s_b[g]) begin
				s_stable[g] <= s_b[g];
			end
		end
	end

	// change detection waits until the filter holds real pin levels,
	// so a pin that idles high gives no false event after reset
	always_ff @(posedge SYS_CLK_I) begin
		if (!RESET_N_I) begin
			settle_cnt <= '0;
		end else if (!primed) begin
			settle_cnt <= settle_cnt + 1'b1;
		end
	end
	assign primed = (settle_cnt == SETTLE_W'(SYNC_SETTLE));

	////////////////////////////////////////////////////////////////////////
	// second port pin drive
	logic [SECOND_WIDTH-1:0] eff_oe;
	logic [SECOND_WIDTH-1:0] eff_val;
	always_comb begin
		eff_oe = second_dir[SECOND_WIDTH-1:0]; // [RQ12]
		eff_val = second_data[SECOND_WIDTH-1:0]; // [RQ6]
		for (int i = 0; i < 5; i++) begin
			if (PWM_CHANNEL_EN_I[i]) begin
				eff_oe[i] = 1'b1; // [RQ13]
				eff_val[i] = PWM_VALUE_I[i]; // [RQ8]
			end
		end
		if (PWM_SHUTDOWN_EN_I) begin
			eff_oe[SHUTDOWN_BIT] = 1'b0; // [RQ14]
			eff_val[SHUTDOWN_BIT] = 1'b0; // [RQ8]
		end else if (PWM_CHANNEL_EN_I[SHUTDOWN_BIT]) begin
			eff_oe[SHUTDOWN_BIT] = 1'b1; // [RQ13]
			eff_val[SHUTDOWN_BIT] = PWM_VALUE_I[SHUTDOWN_BIT]; // [RQ8]
		end
		eff_oe[UNUSED_BIT] = 1'b0; // [RQ15]
		eff_val[UNUSED_BIT] = 1'b0;
	end

	always_ff @(posedge SYS_CLK_I) begin
		if (!RESET_N_I) begin
			SECOND_PIN_O <= '0;
			SECOND_PIN_OE_O <= '0;
			SECOND_PIN_SYNC_O <= '0;
		end else begin
			SECOND_PIN_O <= eff_val;
			SECOND_PIN_OE_O <= eff_oe;
			SECOND_PIN_SYNC_O <= s_stable;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// first port drive and pull selection
	always_comb begin
		pull.pull_en = FIRST_PULL_EN_I;
		pull.pull_down = pull.pull_en & first_polarity[FIRST_WIDTH-1:0];
		pull.pull_up = pull.pull_en & ~first_polarity[FIRST_WIDTH-1:0];
		if (CAN_ACTIVE_I) begin
			pull.pull_down[CAN_RX_BIT] = 1'b0; // [RQ2]
		end
	end

	always_ff @(posedge SYS_CLK_I) begin
		if (!RESET_N_I) begin
			FIRST_PULL_UP_O <= '0;
			FIRST_PULL_DOWN_O <= '0;
		end else begin
			FIRST_PULL_UP_O <= pull.pull_up; // [RQ1]
			FIRST_PULL_DOWN_O <= pull.pull_down; // [RQ1]
		end
	end

	// open-drain only acts on pins that are used as outputs
	for (genvar g = 0; g < FIRST_WIDTH; g++) begin : g_first_drive
		always_ff @(posedge SYS_CLK_I) begin
			if (!RESET_N_I) begin
				FIRST_PIN_O[g] <= 1'b0;
				FIRST_PIN_OE_O[g] <= 1'b0;
			end else if (FIRST_OUT_DIR_I[g] && first_open_drain[g]) begin
				FIRST_PIN_O[g] <= 1'b0; // [RQ3]
				FIRST_PIN_OE_O[g] <= ~FIRST_OUT_VALUE_I[g]; // [RQ3] [RQ4]
			end else begin
				FIRST_PIN_O[g] <= FIRST_OUT_VALUE_I[g];
				FIRST_PIN_OE_O[g] <= FIRST_OUT_DIR_I[g]; // [RQ4]
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// pin change interrupts, sampled on the synchronised pin in any direction
	logic [7:0] pin_event;
	logic rd_status;
	always_comb begin
		pin_event = '0;
		if (primed) begin
			pin_event[SECOND_WIDTH-1:0] = s_stable ^ s_prev; // [RQ9]
		end
		pin_event = pin_event & SECOND_IMPL_MASK;
	end
	assign rd_status = pending && pend_read && hit(req.address, OFS_IRQ_STATUS);

	always_ff @(posedge SYS_CLK_I) begin
		if (!RESET_N_I) begin
			s_prev <= '0;
			irq_status <= '0;
		end else begin
			s_prev <= s_stable;
			if (rd_status) begin
				// only the bits handed out are cleared; an event wins
				irq_status <= (irq_status & ~AVS_READDATA_O[7:0]) | pin_event;
			end else begin
				irq_status <= irq_status | pin_event;
			end
		end
	end

	always_ff @(posedge SYS_CLK_I) begin
		if (!RESET_N_I) begin
			IRQ_O <= 1'b0;
		end else begin
			IRQ_O <= |(irq_status & irq_mask);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// avalon slave: one wait state, answer on the second cycle
	// one-hot bus state: idle, then a single answer cycle
	always_comb begin
		next_bus_state = bus_state;
		unique case (bus_state)
			BUS_IDLE: begin
				if (req.read || req.write) begin
					next_bus_state = BUS_ANSWER;
				end
			end
			BUS_ANSWER: begin
				next_bus_state = BUS_IDLE;
			end
			default: begin
				next_bus_state = BUS_IDLE;
			end
		endcase
	end

	always_ff @(posedge SYS_CLK_I) begin
		if (!RESET_N_I) begin
			bus_state <= BUS_IDLE;
		end else begin
			bus_state <= next_bus_state;
		end
	end
	assign pending = (bus_state == BUS_ANSWER);

	// waitrequest idles high and drops only in the answer cycle
	always_ff @(posedge SYS_CLK_I) begin
		if (!RESET_N_I) begin
			pend_read <= 1'b0;
			AVS_WAITREQUEST_O <= 1'b1;
		end else begin
			AVS_WAITREQUEST_O <= (next_bus_state != BUS_ANSWER);
			if (!pending) begin
				pend_read <= req.read;
			end
		end
	end

	logic wr_now;
	logic [7:0] wbyte;
	logic we_second_data;
	logic we_second_dir;
	logic we_first_polarity;
	logic we_first_open_drain;
	logic we_irq_mask;
	assign wr_now = pending && !pend_read && AVS_BYTEENABLE_I[0];
	assign wbyte = req.writedata[7:0];
	// one write enable per register; input, status and reserved have none
	// input register and reserved slot take no write [RQ5] [RQ11]
	assign we_second_data = wr_now
		&& hit(req.address, OFS_SECOND_DATA);
	assign we_second_dir = wr_now
		&& hit(req.address, OFS_SECOND_DIR);
	assign we_first_polarity = wr_now
		&& hit(req.address, OFS_FIRST_POLARITY);
	assign we_first_open_drain = wr_now
		&& hit(req.address, OFS_FIRST_OPEN_DRAIN);
	assign we_irq_mask = wr_now
		&& hit(req.address, OFS_IRQ_MASK);

	always_ff @(posedge SYS_CLK_I) begin
		if (!RESET_N_I) begin
			second_data <= RST_SECOND_DATA;
		end else if (we_second_data) begin
			second_data <= wbyte & SECOND_IMPL_MASK; // [RQ15]
		end
	end

	always_ff @(posedge SYS_CLK_I) begin
		if (!RESET_N_I) begin
			second_dir <= RST_SECOND_DIR;
		end else if (we_second_dir) begin
			second_dir <= wbyte & SECOND_IMPL_MASK; // [RQ12] [RQ15]
		end
	end

	always_ff @(posedge SYS_CLK_I) begin
		if (!RESET_N_I) begin
			first_polarity <= RST_FIRST_POLARITY;
		end else if (we_first_polarity) begin
			first_polarity <= wbyte & FIRST_IMPL_MASK; // [RQ1]
		end
	end

	always_ff @(posedge SYS_CLK_I) begin
		if (!RESET_N_I) begin
			first_open_drain <= RST_FIRST_OPEN_DRAIN;
		end else if (we_first_open_drain) begin
			first_open_drain <= wbyte & FIRST_IMPL_MASK; // [RQ4]
		end
	end

	always_ff @(posedge SYS_CLK_I) begin
		if (!RESET_N_I) begin
			irq_mask <= RST_IRQ_MASK;
		end else if (we_irq_mask) begin
			irq_mask <= wbyte & SECOND_IMPL_MASK;
		end
	end

	logic [7:0] rd_val;
	logic [7:0] pin_byte;
	always_comb begin
		pin_byte = '0;
		pin_byte[SECOND_WIDTH-1:0] = s_stable;
		rd_val = 8'h00;
		unique case (1'b1)
			hit(req.address, OFS_SECOND_DATA): begin
				rd_val = readback(second_dir, second_data, pin_byte)
					& SECOND_IMPL_MASK; // [RQ7]
			end
			hit(req.address, OFS_SECOND_INPUT): begin
				rd_val = pin_byte & SECOND_IMPL_MASK; // [RQ10]
			end
			hit(req.address, OFS_SECOND_DIR): rd_val = second_dir;
			hit(req.address, OFS_FIRST_POLARITY): rd_val = first_polarity;
			hit(req.address, OFS_FIRST_OPEN_DRAIN): rd_val = first_open_drain;
			hit(req.address, OFS_IRQ_STATUS): rd_val = irq_status;
			hit(req.address, OFS_IRQ_MASK): rd_val = irq_mask;
			hit(req.address, OFS_RESERVED): rd_val = 8'h00; // [RQ5]
			default: rd_val = 8'h00;
		endcase
	end

	always_ff @(posedge SYS_CLK_I) begin
		if (!RESET_N_I) begin
			AVS_READDATA_O <= 32'h00000000;
		end else if (req.read && !pending) begin
			AVS_READDATA_O <= {24'h000000, rd_val};
		end
	end
endmodule

// file: core/port_pin_pkg.sv
// shared constants and carrier types for the port pin control block
package port_pin_pkg;
	localparam int ADDR_W = 10;
	localparam int FIRST_W = 6;
	localparam int SECOND_W = 8;
	localparam int CAN_RX_BIT = 0;
	localparam int SHUTDOWN_BIT = 5;
	localparam int UNUSED_BIT = 6;
	localparam int SYNC_SETTLE = 5;
	localparam int SETTLE_W = 3;
	localparam logic [ADDR_W-1:0] OFS_FIRST_POLARITY = 10'h250;
	localparam logic [ADDR_W-1:0] OFS_FIRST_OPEN_DRAIN = 10'h254;
	localparam logic [ADDR_W-1:0] OFS_RESERVED = 10'h26C;
	localparam logic [ADDR_W-1:0] OFS_SECOND_DATA = 10'h258;
	localparam logic [ADDR_W-1:0] OFS_SECOND_INPUT = 10'h25C;
	localparam logic [ADDR_W-1:0] OFS_SECOND_DIR = 10'h260;
	localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS = 10'h264;
	localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 10'h268;
	localparam logic [7:0] RST_SECOND_DATA = 8'h00;
	localparam logic [7:0] RST_SECOND_DIR = 8'h00;
	localparam logic [7:0] RST_FIRST_POLARITY = 8'h00;
	localparam logic [7:0] RST_FIRST_OPEN_DRAIN = 8'h00;
	localparam logic [7:0] RST_IRQ_MASK = 8'h00;
	localparam logic [7:0] SECOND_IMPL_MASK = 8'hBF;
	localparam logic [7:0] FIRST_IMPL_MASK = 8'h3F;
	typedef struct packed {
		logic read;
		logic write;
		logic [ADDR_W-1:0] address;
		logic [31:0] writedata;
	} bus_req_s;
	typedef struct packed {
		logic [FIRST_W-1:0] pull_en;
		logic [FIRST_W-1:0] pull_down;
		logic [FIRST_W-1:0] pull_up;
	} pull_ctl_s;
endpackage

// file: bench/port_pin_control_asserts.sv
// port-level assertions for the port pin control block
`timescale 1ns/1ns
module port_pin_control_asserts (
	input wire logic SYS_CLK_I,
	input wire logic RESET_N_I,
	input wire logic [9:0] AVS_ADDRESS_I,
	input wire logic AVS_READ_I,
	input wire logic AVS_WRITE_I,
	input wire logic [31:0] AVS_READDATA_O,
	input wire logic AVS_WAITREQUEST_O,
	input wire logic [5:0] FIRST_OUT_DIR_I,
	input wire logic [5:0] FIRST_PULL_EN_I,
	input wire logic CAN_ACTIVE_I,
	input wire logic [5:0] FIRST_PIN_OE_O,
	input wire logic [5:0] FIRST_PULL_UP_O,
	input wire logic [5:0] FIRST_PULL_DOWN_O,
	input wire logic [5:0] PWM_CHANNEL_EN_I,
	input wire logic PWM_SHUTDOWN_EN_I,
	input wire logic [7:0] SECOND_PIN_O,
	input wire logic [7:0] SECOND_PIN_OE_O
);
	import port_pin_pkg::*;
	default clocking @(posedge SYS_CLK_I); endclocking
	default disable iff (!RESET_N_I);
	a_wait_one_cycle: assert property (
		(AVS_READ_I || AVS_WRITE_I) && AVS_WAITREQUEST_O |=> !AVS_WAITREQUEST_O)
		else $error("wait too long");
	a_reserved_zero: assert property (
		AVS_READ_I && AVS_WAITREQUEST_O && AVS_ADDRESS_I == OFS_RESERVED
		|=> AVS_READDATA_O == 32'h0) else $error("reserved not zero");
	a_bit6_idle: assert property (
		(SECOND_PIN_O[6] | SECOND_PIN_OE_O[6]) == 1'b0) else $error("bit6");
	a_channel_forces_out: assert property (
		|PWM_CHANNEL_EN_I[4:0] |=> (SECOND_PIN_OE_O[4:0]
		& $past(PWM_CHANNEL_EN_I[4:0])) == $past(PWM_CHANNEL_EN_I[4:0]))
		else $error("channel not out");
	a_shutdown_input: assert property (
		PWM_SHUTDOWN_EN_I [*2] |=> !SECOND_PIN_OE_O[5]) else $error("shutdown");
	a_pull_select: assert property (
		1'b1 |=> ((FIRST_PULL_UP_O & FIRST_PULL_DOWN_O) | ((FIRST_PULL_UP_O
		| FIRST_PULL_DOWN_O) & ~$past(FIRST_PULL_EN_I))) == 6'h00)
		else $error("pull select");
	a_can_pull: assert property (
		CAN_ACTIVE_I |=> !FIRST_PULL_DOWN_O[0]) else $error("can pull");
	a_input_undriven: assert property (
		1'b1 |=> (FIRST_PIN_OE_O & ~$past(FIRST_OUT_DIR_I)) == 6'h00)
		else $error("input driven");
	c_write: cover property (AVS_WRITE_I && !AVS_WAITREQUEST_O);
	c_shutdown: cover property (PWM_SHUTDOWN_EN_I);
	c_can: cover property (CAN_ACTIVE_I && FIRST_PULL_EN_I[0]);
endmodule
bind port_pin_control port_pin_control_asserts u_port_pin_control_asserts (.*);

// file: bench/pad_model.sv
// outside world of the second port pads: drive, outside level, shorts
`timescale 1ns/1ns
module pad_model (
	input wire logic [7:0] drive_i,
	input wire logic [7:0] enable_i,
	input wire logic [7:0] outside_i,
	input wire logic [7:0] short_en_i,
	input wire logic [7:0] short_val_i,
	output logic [7:0] pad_o
);
	// a short overrides whatever the pad driver does
	assign pad_o = (short_en_i & short_val_i) | (~short_en_i
		& ((enable_i & drive_i) | (~enable_i & outside_i)));
endmodule

// file: bench/port_pin_control_tb.sv
// self-checking bench for the port pin control block
`timescale 1ns/1ns
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin failures++; \
	$display("BAD %0t %h %h", $time, a, b); end end
module port_pin_control_tb;
	import port_pin_pkg::*;
	logic clk = 0, rst_n = 0, rd = 0, wr = 0, can = 0, shut = 0, wq, irq;
	logic [9:0] addr = 10'h000;
	logic [7:0] wd = 8'h00, q, ext = 8'h00, se = 8'h00, sv = 8'h00;
	logic [5:0] pe = 6'h00, od = 6'h00, ov = 6'h00, ch = 6'h00, pv = 6'h00;
	logic [5:0] fp, foe, fup, fdn;
	logic [7:0] sp, soe, pads, sync;
	logic [31:0] rdat;
	int failures = 0, tests_run = 0;
	always #2 clk = ~clk;
	port_pin_control u_port_pin_control (.SYS_CLK_I(clk), .RESET_N_I(rst_n),
		.AVS_ADDRESS_I(addr), .AVS_READ_I(rd), .AVS_WRITE_I(wr),
		.AVS_WRITEDATA_I({24'h000000, wd}), .AVS_BYTEENABLE_I(4'hF),
		.AVS_READDATA_O(rdat), .AVS_WAITREQUEST_O(wq), .FIRST_PIN_I(6'h00),
		.FIRST_OUT_VALUE_I(ov), .FIRST_OUT_DIR_I(od), .FIRST_PULL_EN_I(pe),
		.CAN_ACTIVE_I(can), .FIRST_PIN_O(fp), .FIRST_PIN_OE_O(foe),
		.FIRST_PULL_UP_O(fup), .FIRST_PULL_DOWN_O(fdn), .SECOND_PIN_I(pads),
		.PWM_CHANNEL_EN_I(ch), .PWM_VALUE_I(pv), .PWM_SHUTDOWN_EN_I(shut),
		.SECOND_PIN_O(sp), .SECOND_PIN_OE_O(soe), .SECOND_PIN_SYNC_O(sync),
		.IRQ_O(irq));
	pad_model u_pad_model (.drive_i(sp), .enable_i(soe), .outside_i(ext),
		.short_en_i(se), .short_val_i(sv), .pad_o(pads));
	////////////////////////////////////////////////////////////////////////
	task automatic bus(input logic w, input logic [9:0] a, input logic [7:0] d);
		int n;
		n = 0;
		rd <= !w;
		wr <= w;
		addr <= a;
		wd <= d;
		do begin
			@(posedge clk);
			n++;
		end while (wq !== 1'b0 && n < 40);
		if (n >= 40) failures++;
		q = rdat[7:0];
		rd <= 1'b0;
		wr <= 1'b0;
		@(posedge clk);
	endtask
	task automatic rchk(input logic [9:0] a, input logic [7:0] e);
		bus(1'b0, a, 8'h00);
		`CHK(q, e)
	endtask
	task automatic settle;
		repeat (8) @(posedge clk);
	endtask
	task automatic finish_test;
		if (failures == 0 && tests_run > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	initial begin
		repeat (2000) @(posedge clk);
		failures++;
		finish_test;
	end
	////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		rchk(OFS_IRQ_MASK, 8'h00);
		bus(1'b1, OFS_RESERVED, 8'hFF);
		rchk(OFS_RESERVED, 8'h00);
		rchk(10'h3F0, 8'h00);
		pe <= 6'h3F;
		can <= 1'b1;
		bus(1'b1, OFS_FIRST_POLARITY, 8'h2B);
		settle;
		`CHK({fdn, fup}, {6'h2A, 6'h14})
		can <= 1'b0;
		settle;
		`CHK({fdn, fup}, {6'h2B, 6'h14})
		od <= 6'h3F;
		ov <= 6'h0F;
		bus(1'b1, OFS_FIRST_OPEN_DRAIN, 8'h3F);
		settle;
		`CHK({foe, fp & foe}, {6'h30, 6'h00})
		bus(1'b1, OFS_FIRST_OPEN_DRAIN, 8'h01);
		settle;
		`CHK({foe, fp & foe}, {6'h3E, 6'h0E})
		ext <= 8'hA0;
		bus(1'b1, OFS_SECOND_DIR, 8'hFF);
		bus(1'b1, OFS_SECOND_DATA, 8'hFF);
		settle;
		`CHK({soe, sp}, {8'hBF, 8'hBF})
		rchk(OFS_SECOND_DIR, 8'hBF);
		bus(1'b1, OFS_SECOND_DIR, 8'h0F);
		bus(1'b1, OFS_SECOND_DATA, 8'h05);
		se <= 8'h01;
		settle;
		rchk(OFS_SECOND_DATA, 8'hA5);
		rchk(OFS_SECOND_INPUT, 8'hA4);
		`CHK(sync, 8'hA4)
		bus(1'b1, OFS_SECOND_INPUT, 8'hFF);
		rchk(OFS_SECOND_INPUT, 8'hA4);
		se <= 8'h00;
		bus(1'b1, OFS_SECOND_DIR, 8'h20);
		ch <= 6'h3F;
		pv <= 6'h15;
		shut <= 1'b1;
		settle;
		`CHK({soe[5:0], sp[4:0]}, {6'h1F, 5'h15})
		rchk(OFS_SECOND_DIR, 8'h20);
		ch <= 6'h00;
		shut <= 1'b0;
		bus(1'b1, OFS_SECOND_DIR, 8'h01);
		bus(1'b1, OFS_SECOND_DATA, 8'h00);
		settle;
		bus(1'b0, OFS_IRQ_STATUS, 8'h00);
		bus(1'b1, OFS_IRQ_MASK, 8'h80);
		bus(1'b1, OFS_SECOND_DATA, 8'h01);
		settle;
		`CHK(irq, 1'b0)
		ext <= 8'h20;
		settle;
		`CHK(irq, 1'b1)
		rchk(OFS_IRQ_STATUS, 8'h81);
		settle;
		`CHK(irq, 1'b0)
		finish_test;
	end
endmodule
